/* inc/sg_dma_pkg.sv */
// Purpose: shared constants and types of the scatter-gather engine
// Assumes: 25 MHz engine clock, byte offsets inside the control window
// Notes:   descriptor field positions are relative to the second 64-bit word
package sg_dma_pkg;
  // ************************************************************
  // register map of the control window
  // ************************************************************
  localparam logic [15:0] OFS_SCRATCH  = 16'hFC00;
  localparam logic [15:0] OFS_START    = 16'hFC04;
  localparam logic [15:0] OFS_DADDR0   = 16'hFC08;
  localparam logic [15:0] OFS_STAT0_LO = 16'hFC10;
  localparam logic [15:0] OFS_STAT0_HI = 16'hFC14;
  localparam logic [15:0] OFS_DADDR1   = 16'hFC18;
  localparam logic [15:0] OFS_STAT1_LO = 16'hFC20;
  localparam logic [15:0] OFS_STAT1_HI = 16'hFC24;
  localparam logic [15:0] OFS_RATE     = 16'hFC28;
  localparam logic [15:0] OFS_DIP      = 16'hFC30;
  localparam logic [15:0] OFS_LAMP     = 16'hFCA0;
  localparam logic [15:0] RAM_BYTES    = 16'h1000;
  localparam int          RAM_AW       = 10;
  localparam int          RAM_WORDS    = 1024;
  localparam logic [31:0] CLK_HZ       = 32'h017D_7840;
  localparam logic [15:0] START_CMD    = 16'h0001;
  // ************************************************************
  // descriptor layout and limits
  // ************************************************************
  localparam int          CTL_LSB   = 64;
  localparam int          P_SIZE_HI = 20;
  localparam int          P_DIR_LO  = 21;
  localparam int          P_DIR_HI  = 22;
  localparam int          P_LAST    = 23;
  localparam int          P_MARK_LO = 24;
  localparam int          P_MARK_HI = 31;
  localparam int          P_OFS_LO  = 32;
  localparam int          P_OFS_HI  = 55;
  localparam logic [7:0]  MARK_OK   = 8'hAA;
  localparam logic [1:0]  DIR_HOST_RD = 2'h1;
  localparam logic [1:0]  DIR_HOST_WR = 2'h2;
  localparam logic [20:0] SIZE_MIN  = 21'h00_0008;
  localparam logic [20:0] SIZE_MAX  = 21'h10_0000;
  localparam logic [20:0] BEAT_BYTES = 21'h00_0004;
  localparam logic [31:0] DDR_BASE  = 32'h0000_0000;
  localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;
  localparam logic [2:0]  BATCH_LAST = 3'h7;
  localparam logic [7:0]  ERR_NONE   = 8'h00;
  localparam logic [7:0]  ERR_MARKER = 8'h01;
  localparam logic [7:0]  ERR_SIZE   = 8'h02;
  localparam logic [7:0]  ERR_DIR    = 8'h03;
  localparam int          FIFO_W = 32;
  localparam int          FIFO_D = 32;
  // ************************************************************
  // engine states, gray along idle-fetch-decode-move
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_FETCH  = 3'b001,
    ST_DECODE = 3'b011,
    ST_XFER   = 3'b010
  } eng_state_t;
endpackage

/* inc/desc_if.sv */
`timescale 1ns/1ps
// Purpose: carries one raw descriptor and its decoded fields
// Assumes: purely combinational between engine and decoder
// Notes:   none
interface desc_if;
  logic [127:0] word;
  logic [31:0]  host_addr;
  logic [31:0]  ddr_addr;
  logic [20:0]  size;
  logic [1:0]   dir;
  logic         last;
  logic         valid;
  logic         size_ok;
  logic         dir_ok;
  modport engine  (output word, input host_addr, ddr_addr, size, dir, last, valid, size_ok, dir_ok);
  modport decoder (input word, output host_addr, ddr_addr, size, dir, last, valid, size_ok, dir_ok);
endinterface

/* rtl/desc_decoder.sv */
`timescale 1ns/1ps
// Purpose: splits a 16-byte descriptor into its fields
// Assumes: first 64-bit word holds the host address, second the control
// Notes:   pure logic, no state
module desc_decoder
  import sg_dma_pkg::*;
(
  // descriptor carrier
  desc_if.decoder dsc
);
  logic [63:0] ctl_word;

  // second word holds size, direction, last, marker and ddr offset
  assign ctl_word      = dsc.word[127:CTL_LSB];
  assign dsc.host_addr = dsc.word[31:0];
  assign dsc.size      = ctl_word[P_SIZE_HI:0];
  assign dsc.size_ok   = (dsc.size >= SIZE_MIN) && (dsc.size <= SIZE_MAX);
  assign dsc.dir       = ctl_word[P_DIR_HI:P_DIR_LO];
  assign dsc.dir_ok    = (dsc.dir == DIR_HOST_RD) || (dsc.dir == DIR_HOST_WR);
  assign dsc.last      = ctl_word[P_LAST];
  assign dsc.valid     = (ctl_word[P_MARK_HI:P_MARK_LO] == MARK_OK);
  // offset is only 24 bits wide, so the top byte comes from the base alone
  assign dsc.ddr_addr  = DDR_BASE + {8'h00, ctl_word[P_OFS_HI:P_OFS_LO]};
endmodule

/* rtl/data_fifo.sv */
`timescale 1ns/1ps
// Purpose: elastic buffer in the data path between source and sink
// Assumes: depth is a power of two
// Notes:   ready and valid are combinational from the pointers
module data_fifo #(
  parameter int W = 32,
  parameter int D = 32
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wr_reg;
  logic [AW:0]  wr_next;
  logic [AW:0]  rd_reg;
  logic [AW:0]  rd_next;
  logic         push;
  logic         pop;

  // extra pointer bit tells full from empty
  assign in_ready  = (wr_reg[AW] == rd_reg[AW]) || (wr_reg[AW-1:0] != rd_reg[AW-1:0]);
  assign out_valid = (wr_reg != rd_reg);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_reg[AW-1:0]];

  // pointer next values
  always_comb begin
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
  end

  // pointer registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  // storage, no reset needed since empty hides it
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end
endmodule

/* rtl/sg_dma_control_and_descriptor.sv */
`timescale 1ns/1ps
// Purpose: control window, descriptor walker and data mover control
// Assumes: window accesses are single-cycle strobes on SYS_CLK
// Notes:   one engine serves both channels in turn, channel zero first
// Contract
// - scratch word in the window reads back what software last wrote
// - each channel takes its descriptor list address from its own register
// - status is cycles high word, error byte and byte count low word
// - clock rate word is constant and ignores writes
// - a 4 KB ram in the window is readable and writable
// - descriptor low 32 bits give the host buffer address
// - size field gives bytes, legal from 8 bytes to 1 MB
// - direction 01 reads host memory, 10 writes host memory
// - last bit ends the operation after that descriptor finishes
// - descriptor counts as valid only with marker AA
// - ddr address is offset field added to zero base
// - separate interrupt vectors for two switches and two channels
// - fetch eight descriptors, process each, fetch more until done
// - cycle counter runs in every cycle of the transfer state, whether data moves or stalls
module sg_dma_control_and_descriptor
  import sg_dma_pkg::*;
(
  // clock and reset
  input  wire logic         SYS_CLK,
  input  wire logic         NRST,
  // control window
  input  wire logic         REG_WR,
  input  wire logic         REG_RD,
  input  wire logic [15:0]  REG_ADDR,
  input  wire logic [31:0]  REG_WDATA,
  output logic [31:0]       REG_RDATA,
  output logic              REG_RVALID,
  // descriptor fetch from host memory
  output logic              DESC_REQ,
  output logic [31:0]       DESC_ADDR,
  input  wire logic         DESC_ACK,
  input  wire logic [127:0] DESC_DATA,
  // transfer command
  output logic              XFER_GO,
  output logic              XFER_CHAN,
  output logic [1:0]        XFER_DIR,
  output logic [31:0]       XFER_HOST_ADDR,
  output logic [31:0]       XFER_DDR_ADDR,
  output logic [20:0]       XFER_LEN,
  // data stream
  input  wire logic         IN_VALID,
  output logic              IN_READY,
  input  wire logic [31:0]  IN_DATA,
  output logic              OUT_VALID,
  input  wire logic         OUT_READY,
  output logic [31:0]       OUT_DATA,
  // board io and interrupts
  input  wire logic [31:0]  DIP_SW,
  input  wire logic         FIRST_PUSH_SWITCH,
  input  wire logic         SECOND_PUSH_SWITCH,
  output logic [31:0]       LAMP_OUT,
  output logic [3:0]        IRQ_VEC
);
  // ************************************************************
  // declarations
  // ************************************************************
  logic [31:0] ram [RAM_WORDS];
  logic [127:0] desc_mem [8];
  logic [31:0] scratch_reg, scratch_next, start_reg, start_next;
  logic [1:0][31:0] daddr_reg, daddr_next;
  logic [31:0] lamp_reg, lamp_next, rdata_reg, rdata_next;
  logic        rvalid_reg, rvalid_next;
  logic [1:0]  swp_reg, swp_next, swirq_reg, swirq_next;
  logic [1:0]  start_wr;
  eng_state_t  st_reg, st_next;
  logic        ch_reg, ch_next, go_reg, go_next, last_reg, last_next;
  logic [2:0]  fidx_reg, fidx_next, pidx_reg, pidx_next;
  logic [31:0] faddr_reg, faddr_next, host_reg, host_next, ddr_reg, ddr_next;
  logic [20:0] len_reg, len_next, outl_reg, outl_next, beat;
  logic [1:0]  dir_reg, dir_next, pend_reg, pend_next, take, dirq_reg, dirq_next;
  logic [18:0] inl_reg, inl_next;
  logic [21:0] wsum;
  logic [1:0][31:0] cyc_reg, cyc_next;
  logic [1:0][7:0]  err_reg, err_next;
  logic [1:0][23:0] byt_reg, byt_next;
  logic        in_gate, fifo_in_ready, out_fire;
  desc_if      dsc ();

  // ************************************************************
  // helpers
  // ************************************************************
  desc_decoder u_dec (
    .dsc (dsc)
  );
  assign dsc.word = desc_mem[pidx_reg];

  // the sink may stall, so the fifo fills and pushes back on the source
  assign in_gate  = (st_reg == ST_XFER) && (inl_reg != 19'h0_0000);
  assign IN_READY = fifo_in_ready && in_gate;
  data_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk       (SYS_CLK),
    .nrst      (NRST),
    .in_valid  (IN_VALID && in_gate),
    .in_ready  (fifo_in_ready),
    .in_data   (IN_DATA),
    .out_valid (OUT_VALID),
    .out_ready (OUT_READY),
    .out_data  (OUT_DATA)
  );
  assign out_fire = OUT_VALID && OUT_READY;
  assign beat     = (outl_reg >= BEAT_BYTES) ? BEAT_BYTES : outl_reg;
  assign wsum     = {1'b0, dsc.size} + 22'h00_0003;

  // ************************************************************
  // control window
  // ************************************************************
  assign start_wr[0] = REG_WR && (REG_ADDR == OFS_START) && (REG_WDATA[15:0] == START_CMD);
  assign start_wr[1] = REG_WR && (REG_ADDR == OFS_START) && (REG_WDATA[31:16] == START_CMD);

  // register writes, read mux and switch edge events
  always_comb begin
    scratch_next = scratch_reg;
    start_next   = start_reg;
    daddr_next   = daddr_reg;
    lamp_next    = lamp_reg;
    rdata_next   = rdata_reg;
    rvalid_next  = REG_RD;
    swp_next     = {SECOND_PUSH_SWITCH, FIRST_PUSH_SWITCH};
    swirq_next   = {SECOND_PUSH_SWITCH, FIRST_PUSH_SWITCH} & ~swp_reg;
    if (REG_WR) begin
      case (REG_ADDR)
        OFS_SCRATCH: scratch_next = REG_WDATA;
        OFS_START:   start_next = REG_WDATA;
        OFS_DADDR0:  daddr_next[0] = REG_WDATA;
        OFS_DADDR1:  daddr_next[1] = REG_WDATA;
        OFS_LAMP:    lamp_next = REG_WDATA;
        default:     ;                                            // rate word ignores writes
      endcase
    end
    if (REG_RD) begin
      if (REG_ADDR < RAM_BYTES) begin
        rdata_next = ram[REG_ADDR[RAM_AW+1:2]];
      end else begin
        case (REG_ADDR)
          OFS_SCRATCH:  rdata_next = scratch_reg;
          OFS_START:    rdata_next = start_reg;
          OFS_DADDR0:   rdata_next = daddr_reg[0];
          OFS_DADDR1:   rdata_next = daddr_reg[1];
          OFS_STAT0_LO: rdata_next = {err_reg[0], byt_reg[0]};
          OFS_STAT0_HI: rdata_next = cyc_reg[0];
          OFS_STAT1_LO: rdata_next = {err_reg[1], byt_reg[1]};
          OFS_STAT1_HI: rdata_next = cyc_reg[1];
          OFS_RATE:     rdata_next = CLK_HZ;
          OFS_DIP:      rdata_next = DIP_SW;
          OFS_LAMP:     rdata_next = lamp_reg;
          default:      rdata_next = 32'h0000_0000;
        endcase
      end
    end
  end

  // window registers
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      scratch_reg <= 32'h0000_0000;
      start_reg   <= 32'h0000_0000;
      daddr_reg   <= '0;
      lamp_reg    <= 32'h0000_0000;
      rdata_reg   <= 32'h0000_0000;
      rvalid_reg  <= 1'b0;
      swp_reg     <= 2'b00;
      swirq_reg   <= 2'b00;
    end else begin
      scratch_reg <= scratch_next;
      start_reg   <= start_next;
      daddr_reg   <= daddr_next;
      lamp_reg    <= lamp_next;
      rdata_reg   <= rdata_next;
      rvalid_reg  <= rvalid_next;
      swp_reg     <= swp_next;
      swirq_reg   <= swirq_next;
    end
  end

  // window ram, contents undefined after power-up
  always_ff @(posedge SYS_CLK) begin
    if (REG_WR && (REG_ADDR < RAM_BYTES)) begin
      ram[REG_ADDR[RAM_AW+1:2]] <= REG_WDATA;
    end
  end

  // ************************************************************
  // descriptor engine
  // ************************************************************
  // state walk and status counters
  always_comb begin
    st_next = st_reg;
    ch_next = ch_reg;
    fidx_next = fidx_reg;
    pidx_next = pidx_reg;
    faddr_next = faddr_reg;
    host_next = host_reg;
    ddr_next = ddr_reg;
    len_next = len_reg;
    dir_next = dir_reg;
    last_next = last_reg;
    go_next = 1'b0;
    inl_next = inl_reg;
    outl_next = outl_reg;
    cyc_next = cyc_reg;
    err_next = err_reg;
    byt_next = byt_reg;
    dirq_next = 2'b00;
    take = 2'b00;
    unique case (st_reg)
      ST_IDLE: begin
        if (pend_reg != 2'b00) begin
          ch_next = !pend_reg[0];
          take = pend_reg[0] ? 2'b01 : 2'b10;
          faddr_next = daddr_reg[!pend_reg[0]];
          fidx_next = 3'h0;
          st_next = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (DESC_ACK) begin
          fidx_next = fidx_reg + 3'h1;
          faddr_next = faddr_reg + DESC_STRIDE;
          if (fidx_reg == BATCH_LAST) begin
            pidx_next = 3'h0;
            st_next = ST_DECODE;
          end
        end
      end
      ST_DECODE: begin
        if (!dsc.valid || !dsc.size_ok || !dsc.dir_ok) begin
          // a broken descriptor ends the channel and still interrupts
          err_next[ch_reg] = !dsc.valid ? ERR_MARKER :
                             (!dsc.size_ok ? ERR_SIZE : ERR_DIR);
          dirq_next[ch_reg] = 1'b1;
          st_next = ST_IDLE;
        end else begin
          host_next = dsc.host_addr;
          ddr_next = dsc.ddr_addr;
          len_next = dsc.size;
          dir_next = dsc.dir;
          last_next = dsc.last;
          go_next = 1'b1;
          inl_next = wsum[20:2];
          outl_next = dsc.size;
          st_next = ST_XFER;
        end
      end
      ST_XFER: begin
        cyc_next[ch_reg] = cyc_reg[ch_reg] + 32'h0000_0001;
        if (IN_VALID && IN_READY) begin
          inl_next = inl_reg - 19'h0_0001;
        end
        if (out_fire) begin
          outl_next = outl_reg - beat;
          byt_next[ch_reg] = byt_reg[ch_reg] + {3'h0, beat};
          if (outl_reg == beat) begin
            if (last_reg) begin
              dirq_next[ch_reg] = 1'b1;
              st_next = ST_IDLE;
            end else if (pidx_reg == BATCH_LAST) begin
              fidx_next = 3'h0;
              st_next = ST_FETCH;
            end else begin
              pidx_next = pidx_reg + 3'h1;
              st_next = ST_DECODE;
            end
          end
        end
      end
    endcase
    // a fresh start wipes the channel status, overriding any count
    for (int c = 0; c < 2; c++) begin
      if (start_wr[c]) begin
        cyc_next[c] = 32'h0000_0000;
        err_next[c] = ERR_NONE;
        byt_next[c] = 24'h00_0000;
      end
    end
    // a start that meets its own pick-up is kept, set wins
    pend_next = start_wr | (pend_reg & ~take);
  end

  // engine registers
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      st_reg <= ST_IDLE;
      ch_reg <= 1'b0;
      fidx_reg <= 3'h0;
      pidx_reg <= 3'h0;
      faddr_reg <= 32'h0000_0000;
      host_reg <= 32'h0000_0000;
      ddr_reg <= 32'h0000_0000;
      len_reg <= 21'h00_0000;
      dir_reg <= 2'b00;
      last_reg <= 1'b0;
      go_reg <= 1'b0;
      inl_reg <= 19'h0_0000;
      outl_reg <= 21'h00_0000;
      cyc_reg <= '0;
      err_reg <= '0;
      byt_reg <= '0;
      pend_reg <= 2'b00;
      dirq_reg <= 2'b00;
    end else begin
      st_reg <= st_next;
      ch_reg <= ch_next;
      fidx_reg <= fidx_next;
      pidx_reg <= pidx_next;
      faddr_reg <= faddr_next;
      host_reg <= host_next;
      ddr_reg <= ddr_next;
      len_reg <= len_next;
      dir_reg <= dir_next;
      last_reg <= last_next;
      go_reg <= go_next;
      inl_reg <= inl_next;
      outl_reg <= outl_next;
      cyc_reg <= cyc_next;
      err_reg <= err_next;
      byt_reg <= byt_next;
      pend_reg <= pend_next;
      dirq_reg <= dirq_next;
    end
  end

  // descriptor batch store
  always_ff @(posedge SYS_CLK) begin
    if ((st_reg == ST_FETCH) && DESC_ACK) begin
      desc_mem[fidx_reg] <= DESC_DATA;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign REG_RDATA = rdata_reg;
  assign REG_RVALID = rvalid_reg;
  assign DESC_REQ = (st_reg == ST_FETCH);
  assign DESC_ADDR = faddr_reg;
  assign XFER_GO = go_reg;
  assign XFER_CHAN = ch_reg;
  assign XFER_DIR = dir_reg;
  assign XFER_HOST_ADDR = host_reg;
  assign XFER_DDR_ADDR = ddr_reg;
  assign XFER_LEN = len_reg;
  assign LAMP_OUT = lamp_reg;
  assign IRQ_VEC = {swirq_reg[1], dirq_reg[1], dirq_reg[0], swirq_reg[0]};

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);

  sequence s_scratch_wr_rd;
    (REG_WR && REG_ADDR == OFS_SCRATCH) ##1 !REG_WR ##1 (REG_RD && !REG_WR && REG_ADDR == OFS_SCRATCH);
  endsequence
  sequence s_last_beat;
    st_reg == ST_XFER && out_fire && outl_reg == beat && last_reg;
  endsequence

  a_scratch_readback: assert property (s_scratch_wr_rd |=> REG_RDATA == $past(REG_WDATA, 3))
    else $error("scratch word did not read back");
  a_rate_fixed: assert property (REG_RVALID && $past(REG_ADDR) == OFS_RATE |-> REG_RDATA == CLK_HZ)
    else $error("clock rate word wrong");
  a_fetch_batch: assert property (st_reg == ST_FETCH && DESC_ACK && fidx_reg != BATCH_LAST |=> DESC_REQ)
    else $error("fetch ended before eight descriptors");
  a_batch_decode: assert property (st_reg == ST_FETCH && DESC_ACK && fidx_reg == BATCH_LAST
                                   |=> st_reg == ST_DECODE && pidx_reg == 3'h0)
    else $error("batch did not go to decode");
  a_bad_marker: assert property (st_reg == ST_DECODE && !dsc.valid && start_wr == 2'b00
                                 |=> st_reg == ST_IDLE && err_reg[ch_reg] == ERR_MARKER)
    else $error("bad marker not reported");
  a_cycle_hold: assert property (st_reg != ST_XFER && start_wr == 2'b00 |=> $stable(cyc_reg))
    else $error("cycle count moved outside transfer");
  a_start_clear: assert property (start_wr[0] |=> byt_reg[0] == 24'h00_0000 && cyc_reg[0] == 32'h0000_0000)
    else $error("start did not clear status");
  a_last_stop: assert property (s_last_beat |=> st_reg == ST_IDLE && dirq_reg != 2'b00)
    else $error("last descriptor did not stop engine");
  a_go_fields: assert property (XFER_GO |-> XFER_LEN >= SIZE_MIN && XFER_LEN <= SIZE_MAX
                                && (XFER_DIR == DIR_HOST_RD || XFER_DIR == DIR_HOST_WR))
    else $error("illegal transfer issued");
  a_ddr_offset: assert property (XFER_GO |-> XFER_DDR_ADDR[31:24] == 8'h00)
    else $error("ddr address outside offset range");
  a_switch_irq: assert property (FIRST_PUSH_SWITCH && !swp_reg[0] |=> IRQ_VEC[0] ##1 !IRQ_VEC[0])
    else $error("switch vector not pulsed");
endmodule

/* tb/host_model.sv */
`timescale 1ns/1ps
// Purpose: host memory side that answers descriptor fetches
// Assumes: one descriptor handed over per acknowledged cycle
// Notes:   slow mode answers every other cycle only
module host_model (
  // fetch request
  input  wire logic         clk,
  input  wire logic         req,
  input  wire logic [31:0]  addr,
  // scenario controls
  input  wire logic         slow,
  input  wire logic [7:0]   mark,
  // answer
  output logic              ack,
  output logic [127:0]      data
);
  logic         tick = 1'b0;
  logic [127:0] word;
  // 8 byte host read, last flag, ddr offset 0x40, host address keyed to the fetch address
  assign word = {8'h00, 24'h00_0040, mark, 1'b1, 2'b01, 21'h00_0008, 32'h0000_0000, addr ^ 32'h5A5A_0000};
  // divider for slow answers
  always @(posedge clk) tick <= ~tick;
  assign ack  = req & (~slow | tick);
  // idle bus shows the inverse so a stale word is never taken for a fresh one
  assign data = ack ? word : ~word;
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
// Purpose: self-checking bench of the scatter-gather control block
// Assumes: inputs change on the falling edge of SYS_CLK
// Notes:   switch pulses come last, data stream kept flowing once started
module testbench
  import sg_dma_pkg::*;
;
  logic         SYS_CLK = 1'b0, NRST = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, slow = 1'b0;
  logic         IN_VALID = 1'b0, OUT_READY = 1'b0, FIRST_PUSH_SWITCH = 1'b0, SECOND_PUSH_SWITCH = 1'b0;
  logic [15:0]  REG_ADDR = 16'h0000;
  logic [31:0]  REG_WDATA = 32'h0000_0000, IN_DATA = 32'h0000_0000, DIP_SW = 32'h0000_C3A5;
  logic [7:0]   mark = MARK_OK;
  logic [31:0]  REG_RDATA, DESC_ADDR, XFER_HOST_ADDR, XFER_DDR_ADDR, OUT_DATA, LAMP_OUT;
  logic         REG_RVALID, DESC_REQ, DESC_ACK, XFER_GO, XFER_CHAN, IN_READY, OUT_VALID;
  logic [1:0]   XFER_DIR;
  logic [20:0]  XFER_LEN;
  logic [127:0] DESC_DATA;
  logic [3:0]   IRQ_VEC;
  int           errors = 0, total_checks = 0;
  // ************************************************************
  // clock, design and host side
  // ************************************************************
  always #20 SYS_CLK = ~SYS_CLK;
  always @(negedge SYS_CLK) IN_DATA <= IN_DATA + 32'h0000_0001;
  sg_dma_control_and_descriptor dut (.*);
  host_model host (.clk(SYS_CLK), .req(DESC_REQ), .addr(DESC_ADDR), .slow(slow), .mark(mark),
                   .ack(DESC_ACK), .data(DESC_DATA));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge SYS_CLK) {REG_WR, REG_ADDR, REG_WDATA} = {1'b1, a, d};
    @(negedge SYS_CLK) REG_WR = 1'b0;
  endtask
  // answer stands one cycle, so it is looked at in that cycle
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(negedge SYS_CLK) {REG_RD, REG_ADDR} = {1'b1, a};
    @(negedge SYS_CLK) REG_RD = 1'b0;
    chk({31'h0, REG_RVALID}, 32'h1);
    chk(REG_RDATA, exp);
  endtask
  // sel 0 fetch request, 4 transfer start, else that interrupt line
  task automatic wait_on(input logic [2:0] sel);
    int n = 0;
    while (!(sel == 0 ? DESC_REQ === 1'b1 : sel == 4 ? XFER_GO === 1'b1 : IRQ_VEC[sel[1:0]] === 1'b1)) begin
      @(negedge SYS_CLK);
      n++;
      if (n > 2000) begin
        errors++;
        $display("FAIL %0t timeout", $time);
        test_done();
      end
    end
  endtask
  task automatic regs_check();
    wr(OFS_SCRATCH, 32'hA5C3_0F1E);
    rd(OFS_SCRATCH, 32'hA5C3_0F1E);
    wr(OFS_RATE, 32'h0000_0000);
    wr(16'h0FFC, 32'h1234_5678);
    wr(OFS_LAMP, 32'h0000_00F0);
    rd(OFS_RATE, CLK_HZ);
    rd(16'h0FFC, 32'h1234_5678);
    rd(OFS_DIP, 32'h0000_C3A5);
    chk(LAMP_OUT, 32'h0000_00F0);
    rd(16'hFCFC, 32'h0000_0000);
  endtask
  task automatic move_one();
    wr(OFS_DADDR0, 32'h0000_2000);
    rd(OFS_DADDR0, 32'h0000_2000);
    IN_VALID = 1'b1;
    OUT_READY = 1'b1;
    wr(OFS_START, 32'h0000_0001);
    wait_on(3'd0);
    chk(DESC_ADDR, 32'h0000_2000);
    wait_on(3'd4);
    chk(XFER_HOST_ADDR, 32'h5A5A_2000);
    chk(XFER_DDR_ADDR, 32'h0000_0040);
    chk({11'h0, XFER_LEN}, 32'h0000_0008);
    chk({30'h0, XFER_DIR}, {30'h0, DIR_HOST_RD});
    chk({31'h0, XFER_CHAN}, 32'h0000_0000);
    // first word has passed the fifo one cycle after it was taken
    @(negedge SYS_CLK);
    chk({31'h0, OUT_VALID}, 32'h0000_0001);
    chk(OUT_DATA, IN_DATA);
    wait_on(3'd1);
    @(negedge SYS_CLK);
    chk({31'h0, DESC_REQ}, 32'h0000_0000);
    rd(OFS_STAT0_LO, 32'h0000_0008);
    rd(OFS_STAT0_HI, 32'h0000_0003);
  endtask
  // slow host and a broken marker: channel must stop before moving data
  task automatic bad_mark();
    mark = 8'h55;
    slow = 1'b1;
    wr(OFS_DADDR1, 32'h0000_3000);
    wr(OFS_START, 32'h0001_0000);
    wait_on(3'd2);
    chk({31'h0, XFER_GO}, 32'h0000_0000);
    chk(XFER_HOST_ADDR, 32'h5A5A_2000);
    rd(OFS_STAT1_LO, 32'h0100_0000);
  endtask
  // switch rises give one-cycle pulses on their own vectors
  task automatic sw_irq();
    @(negedge SYS_CLK) FIRST_PUSH_SWITCH = 1'b1;
    @(negedge SYS_CLK) chk({28'h0, IRQ_VEC}, 32'h0000_0001);
    SECOND_PUSH_SWITCH = 1'b1;
    @(negedge SYS_CLK) chk({28'h0, IRQ_VEC}, 32'h0000_0008);
    @(negedge SYS_CLK) chk({28'h0, IRQ_VEC}, 32'h0000_0000);
  endtask
  // reset released on a falling edge after 4 cycles
  initial begin
    #160 NRST = 1'b1;
    regs_check();
    move_one();
    bad_mark();
    sw_irq();
    test_done();
  end
endmodule
